/* File: design/mgw_core.sv */
// Purpose: Request routing and serial transaction timing for a Modbus gateway.
// Assumes: TCP framing is done upstream; serial characters arrive already decoded.
// Notes:   One serial transaction at a time; requests wait on o_req_ready.
// Notes on behaviour
// - Forward to serial only while the port mode is gateway.
// - Gateway acts only when the serial protocol is RTU or Jbus.
// - Broadcasts go downstream only when broadcast forwarding is enabled.
// - Missing downstream reply after the set timeout yields an exception response.
// - Hold the set inter-frame delay after a response before the next request.
// - Frame silence is 3.5 characters plus an extension of 0 to 15.
// - After full silence the next character starts a new frame.
// - Timeout, delay and extension apply only in gateway mode.
// - Open connections are capped at a configurable maximum.
// - Requests from TCP port 502 are converted and sent to the slave.
// - Unit 255 or own unit id are handled locally, others forwarded.
// - Broadcasts with unit zero are always processed locally too.
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module mgw_core #(
  // Cycles per millisecond; a bench may shrink it so that the long timeouts can be reached.
  parameter int unsigned CYC_PER_MS = mgw_pkg::MS_CYC
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  input  wire logic        i_conn_open,
  input  wire logic        i_conn_close,
  output logic             o_conn_accept,
  input  wire logic        i_req_valid,
  input  wire logic [15:0] i_req_port,
  input  wire logic [7:0]  i_req_unit,
  input  wire logic [7:0]  i_req_func,
  output logic             o_req_ready,
  output logic             o_fwd_start,
  output logic      [7:0]  o_fwd_unit,
  output logic      [7:0]  o_fwd_func,
  output logic             o_local,
  output logic             o_serial_busy,
  input  wire logic        i_rx_char,
  input  wire logic        i_rx_done,
  output logic             o_rx_new_frame,
  output logic             o_exc_valid,
  output logic      [7:0]  o_exc_func,
  output logic      [7:0]  o_exc_code
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_HOLD} mgw_state_type;

  logic [7:0]  ctrl_q, ctrl_d;
  logic [3:0]  tmo_q, tmo_d, ifd_q, ifd_d, sie_q, sie_d, maxc_q, maxc_d;
  logic [7:0]  unit_q, unit_d;
  logic [15:0] char_q, char_d;
  logic [15:0] rdata_q, rdata_d;
  logic [3:0]  conn_q, conn_d;
  mgw_state_type st_q, st_d;
  logic [27:0] tmr_q, tmr_d;
  logic [7:0]  func_q, func_d, funit_q, funit_d;
  logic        fwd_q, fwd_d, loc_q, loc_d, exc_q, exc_d, nf_q, nf_d;
  logic        rxc_s1_q, rxc_q, rxd_s1_q, rxd_q, rxc_prev_q, rxd_prev_q;
  logic        rx_char, rx_done, silent, silent_q;
  logic        gw_on, is_bcast, is_self, take, fwd_go;
  logic [27:0] tmo_cyc, ifd_cyc;

  // Serial events come from the transceiver pins, so they are synchronised first.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rxc_s1_q   <= 1'b0;
      rxc_q      <= 1'b0;
      rxd_s1_q   <= 1'b0;
      rxd_q      <= 1'b0;
      rxc_prev_q <= 1'b0;
      rxd_prev_q <= 1'b0;
      silent_q   <= 1'b1;
    end else if (i_ce) begin
      rxc_s1_q   <= i_rx_char;
      rxc_q      <= rxc_s1_q;
      rxd_s1_q   <= i_rx_done;
      rxd_q      <= rxd_s1_q;
      rxc_prev_q <= rxc_q;
      rxd_prev_q <= rxd_q;
      silent_q   <= silent;
    end
  end
  assign rx_char = rxc_q & ~rxc_prev_q;
  assign rx_done = rxd_q & ~rxd_prev_q;

  mgw_gap u_gap (
    .i_clock    (i_clock),
    .i_rst_n    (i_rst_n),
    .i_ce       (i_ce),
    .i_rx_char  (rx_char),
    .i_char_cyc (char_q),
    .i_ext      (gw_on ? sie_q : 4'h0),
    .o_silent   (silent)
  );

  assign gw_on = ctrl_q[mgw_pkg::CTRL_GW_BIT]
    && (ctrl_q[mgw_pkg::CTRL_PROTO_LSB +: 2] == mgw_pkg::PROTO_RTU
     || ctrl_q[mgw_pkg::CTRL_PROTO_LSB +: 2] == mgw_pkg::PROTO_JBUS);
  assign is_bcast = (i_req_unit == mgw_pkg::UNIT_BCAST);
  assign is_self  = (i_req_unit == mgw_pkg::UNIT_SELF) || (i_req_unit == unit_q);

  // Timeout steps: codes 0..4 are 0.1..0.5 s, codes 5..14 are 1..10 s.
  assign tmo_cyc = (tmo_q < 4'h5)
    ? 28'(({24'h000000, tmo_q} + 28'h0000001) * 28'(mgw_pkg::TMO_STEP_MS * CYC_PER_MS))
    : 28'(({24'h000000, tmo_q} - 28'h0000004)
      * 28'(10 * mgw_pkg::TMO_STEP_MS * CYC_PER_MS));
  assign ifd_cyc = 28'({24'h000000, (ifd_q > 4'hA ? 4'hA : ifd_q)}
                 * 28'(mgw_pkg::IFD_STEP_MS * CYC_PER_MS));

  assign o_req_ready = (st_q == ST_IDLE);
  assign take   = i_req_valid && o_req_ready && (i_req_port == mgw_pkg::TCP_PORT);
  assign fwd_go = take && gw_on && !is_self
               && (!is_bcast || ctrl_q[mgw_pkg::CTRL_BCAST_BIT]);

  always_comb begin
    st_d    = st_q;
    tmr_d   = tmr_q;
    func_d  = func_q;
    funit_d = funit_q;
    fwd_d   = 1'b0;
    loc_d   = 1'b0;
    exc_d   = 1'b0;
    nf_d    = rx_char && silent_q;
    unique case (st_q)
      ST_IDLE: begin
        if (take) begin
          loc_d = !fwd_go || is_bcast;
          if (fwd_go) begin
            fwd_d   = 1'b1;
            funit_d = i_req_unit;
            func_d  = i_req_func;
            tmr_d   = 28'h0000000;
            // A broadcast has no reply, so only the inter-frame hold follows.
            st_d    = is_bcast ? ST_HOLD : ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (rx_done) begin
          tmr_d = 28'h0000000;
          st_d  = ST_HOLD;
        end else if (tmr_q + 28'h0000001 >= tmo_cyc) begin
          exc_d = 1'b1;
          tmr_d = 28'h0000000;
          st_d  = ST_HOLD;
        end else begin
          tmr_d = tmr_q + 28'h0000001;
        end
      end
      ST_HOLD: begin
        if (tmr_q >= ifd_cyc) begin
          st_d = ST_IDLE;
        end else begin
          tmr_d = tmr_q + 28'h0000001;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q    <= ST_IDLE;
      tmr_q   <= 28'h0000000;
      func_q  <= 8'h00;
      funit_q <= 8'h00;
      fwd_q   <= 1'b0;
      loc_q   <= 1'b0;
      exc_q   <= 1'b0;
      nf_q    <= 1'b0;
    end else if (i_ce) begin
      st_q    <= st_d;
      tmr_q   <= tmr_d;
      func_q  <= func_d;
      funit_q <= funit_d;
      fwd_q   <= fwd_d;
      loc_q   <= loc_d;
      exc_q   <= exc_d;
      nf_q    <= nf_d;
    end
  end

  // Connection count; an open and a close together leave it unchanged.
  always_comb begin
    conn_d = conn_q;
    if (i_conn_open && conn_q < maxc_q && !i_conn_close) begin
      conn_d = conn_q + 4'h1;
    end else if (i_conn_close && !i_conn_open && conn_q != 4'h0) begin
      conn_d = conn_q - 4'h1;
    end
  end
  assign o_conn_accept = i_conn_open && (conn_q < maxc_q || i_conn_close);

  // Register port.
  always_comb begin
    ctrl_d  = ctrl_q;
    tmo_d   = tmo_q;
    ifd_d   = ifd_q;
    sie_d   = sie_q;
    unit_d  = unit_q;
    maxc_d  = maxc_q;
    char_d  = char_q;
    rdata_d = 16'h0000;
    if (i_wr) begin
      unique case (i_addr)
        mgw_pkg::ADDR_CTRL: ctrl_d = i_wdata[7:0];
        mgw_pkg::ADDR_TMO:  tmo_d  = (i_wdata[3:0] > 4'hE) ? 4'hE : i_wdata[3:0];
        mgw_pkg::ADDR_IFD:  ifd_d  = (i_wdata[3:0] > 4'hA) ? 4'hA : i_wdata[3:0];
        mgw_pkg::ADDR_SIE:  sie_d  = i_wdata[3:0];
        mgw_pkg::ADDR_UNIT: unit_d = i_wdata[7:0];
        mgw_pkg::ADDR_MAXC: maxc_d = i_wdata[3:0];
        mgw_pkg::ADDR_CHAR: char_d = i_wdata;
        default: ;
      endcase
    end
    if (i_rd) begin
      unique case (i_addr)
        mgw_pkg::ADDR_CTRL: rdata_d = {8'h00, ctrl_q};
        mgw_pkg::ADDR_TMO:  rdata_d = {12'h000, tmo_q};
        mgw_pkg::ADDR_IFD:  rdata_d = {12'h000, ifd_q};
        mgw_pkg::ADDR_SIE:  rdata_d = {12'h000, sie_q};
        mgw_pkg::ADDR_UNIT: rdata_d = {8'h00, unit_q};
        mgw_pkg::ADDR_MAXC: rdata_d = {12'h000, maxc_q};
        mgw_pkg::ADDR_STAT: rdata_d = {8'h00, conn_q, silent_q, gw_on, st_q};
        mgw_pkg::ADDR_CHAR: rdata_d = char_q;
        default:            rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q  <= mgw_pkg::RST_CTRL;
      tmo_q   <= mgw_pkg::RST_TMO;
      ifd_q   <= mgw_pkg::RST_IFD;
      sie_q   <= mgw_pkg::RST_SIE;
      unit_q  <= mgw_pkg::RST_UNIT;
      maxc_q  <= mgw_pkg::RST_MAXC;
      char_q  <= mgw_pkg::RST_CHAR;
      rdata_q <= 16'h0000;
      conn_q  <= 4'h0;
    end else if (i_ce) begin
      ctrl_q  <= ctrl_d;
      tmo_q   <= tmo_d;
      ifd_q   <= ifd_d;
      sie_q   <= sie_d;
      unit_q  <= unit_d;
      maxc_q  <= maxc_d;
      char_q  <= char_d;
      rdata_q <= rdata_d;
      conn_q  <= conn_d;
    end
  end

  assign o_rdata        = rdata_q;
  assign o_fwd_start    = fwd_q;
  assign o_fwd_unit     = funit_q;
  assign o_fwd_func     = func_q;
  assign o_local        = loc_q;
  assign o_serial_busy  = (st_q != ST_IDLE);
  assign o_rx_new_frame = nf_q;
  assign o_exc_valid    = exc_q;
  assign o_exc_func     = func_q | mgw_pkg::EXC_FLAG;
  assign o_exc_code     = mgw_pkg::EXC_NORESP;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  fwd_needs_gw_a: assert property (o_fwd_start
      |-> $past(ctrl_q[mgw_pkg::CTRL_GW_BIT]))
    else $error("Forward issued outside gateway mode.");
  proto_gate_a: assert property (o_fwd_start
      |-> $past(ctrl_q[mgw_pkg::CTRL_PROTO_LSB +: 2]) inside {2'h0, 2'h1})
    else $error("Gateway active with a foreign protocol.");
  bcast_gate_a: assert property (o_fwd_start && o_fwd_unit == 8'h00
      |-> $past(ctrl_q[mgw_pkg::CTRL_BCAST_BIT]))
    else $error("Broadcast forwarded while disabled.");
  exc_after_wait_a: assert property (i_ce && o_exc_valid |-> $past(st_q) == ST_WAIT)
    else $error("Exception without a pending wait.");
  hold_min_a: assert property (i_ce && $rose(st_q == ST_IDLE) |-> $past(tmr_q) >= $past(ifd_cyc))
    else $error("Inter-frame hold cut short.");
  new_frame_a: assert property (i_ce && nf_q |-> $past(silent_q))
    else $error("New frame flagged without silence.");
  conn_cap_a: assert property (conn_q > $past(conn_q) |-> $past(conn_q) < $past(maxc_q))
    else $error("Connection count over the cap.");
  self_local_a: assert property (o_fwd_start
      |-> o_fwd_unit != 8'hFF && o_fwd_unit != $past(unit_q))
    else $error("Own-address request forwarded.");
  exc_code_a: assert property (o_exc_valid |-> o_exc_func[7] && o_exc_code == 8'h0B)
    else $error("Bad exception encoding.");

  cov_fwd_c:   cover property (o_fwd_start ##[1:60] rx_done);
  cov_tmo_c:   cover property (o_exc_valid);
  cov_local_c: cover property (o_local && !o_fwd_start);
  cov_frame_c: cover property (o_rx_new_frame);
endmodule
`default_nettype wire

/* File: design/mgw_gap.sv */
// Purpose: Silent interval tracker on the serial receive side.
// Assumes: Character time is given in clock cycles.
// Notes:   Silence is 3.5 characters plus an extension in whole characters.
`timescale 1ns/100ps
`default_nettype none
module mgw_gap (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_rx_char,
  input  wire logic [15:0] i_char_cyc,
  input  wire logic [3:0]  i_ext,
  output logic             o_silent
);
  logic [23:0] cnt_q, cnt_d;
  logic        sil_q, sil_d;
  logic [23:0] limit;

  // Seven half characters, plus the extension in whole characters.
  assign limit = 24'((({8'h00, i_char_cyc} * 24'h000007) >> 1)
               + ({8'h00, i_char_cyc} * {20'h00000, i_ext}));

  always_comb begin
    cnt_d = cnt_q;
    sil_d = sil_q;
    if (i_rx_char) begin
      cnt_d = 24'h000000;
      sil_d = 1'b0;
    end else if (!sil_q) begin
      if (cnt_q + 24'h000001 >= limit) begin
        sil_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 24'h000001;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 24'h000000;
      sil_q <= 1'b1;
    end else if (i_ce) begin
      cnt_q <= cnt_d;
      sil_q <= sil_d;
    end
  end

  assign o_silent = sil_q;
endmodule
`default_nettype wire

/* File: design/mgw_pkg.sv */
// Purpose: Shared constants for the serial gateway core.
// Assumes: 20 MHz clock; register port with one-cycle read latency.
// Notes:   Times are kept in their own units and converted to cycles here.
package mgw_pkg;
  localparam int unsigned CLK_HZ       = 20000000;
  localparam int unsigned TMO_STEP_MS  = 100;
  localparam int unsigned TMO_STEP_CYC = CLK_HZ / 1000 * TMO_STEP_MS;
  localparam int unsigned IFD_STEP_MS  = 10;
  localparam int unsigned IFD_STEP_CYC = CLK_HZ / 1000 * IFD_STEP_MS;
  localparam int unsigned MS_CYC       = CLK_HZ / 1000;

  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_TMO    = 4'h1;
  localparam logic [3:0] ADDR_IFD    = 4'h2;
  localparam logic [3:0] ADDR_SIE    = 4'h3;
  localparam logic [3:0] ADDR_UNIT   = 4'h4;
  localparam logic [3:0] ADDR_MAXC   = 4'h5;
  localparam logic [3:0] ADDR_STAT   = 4'h6;
  localparam logic [3:0] ADDR_CHAR   = 4'h7;

  localparam int CTRL_GW_BIT    = 0;
  localparam int CTRL_BCAST_BIT = 1;
  localparam int CTRL_PROTO_LSB = 2;

  localparam logic [1:0] PROTO_RTU  = 2'h0;
  localparam logic [1:0] PROTO_JBUS = 2'h1;

  localparam logic [7:0]  RST_CTRL  = 8'h00;
  localparam logic [3:0]  RST_TMO   = 4'h9;
  localparam logic [3:0]  RST_IFD   = 4'h0;
  localparam logic [3:0]  RST_SIE   = 4'h0;
  localparam logic [7:0]  RST_UNIT  = 8'h01;
  localparam logic [3:0]  RST_MAXC  = 4'h3;
  localparam logic [15:0] RST_CHAR  = 16'h3A98;

  localparam logic [7:0] UNIT_BCAST = 8'h00;
  localparam logic [7:0] UNIT_SELF  = 8'hFF;
  localparam logic [7:0] EXC_FLAG   = 8'h80;
  localparam logic [7:0] EXC_NORESP = 8'h0B;
  localparam logic [15:0] TCP_PORT  = 16'h01F6;
endpackage

/* File: tb/mgw_core_bench.sv */
// Purpose: Self-checking bench for the gateway core.
// Assumes: Clock enable held high; a two-cycle millisecond keeps timeouts short.
// Notes:   Each scenario is one task that drives and judges.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module mgw_core_bench;
  logic        i_clock, i_rst_n, i_wr, i_rd, i_conn_open, i_conn_close, i_req_valid, slow;
  logic [3:0]  i_addr;
  logic [15:0] i_wdata, i_req_port, o_rdata;
  logic [7:0]  i_req_unit, i_req_func, o_fwd_unit, o_fwd_func, o_exc_func, o_exc_code;
  logic        o_conn_accept, o_req_ready, o_fwd_start, o_local, o_serial_busy;
  logic        rx_char, rx_done, o_rx_new_frame, o_exc_valid;
  int          err_total, n_tests, cyc, nf;

  mgw_core #(.CYC_PER_MS(2)) dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_ce(1'b1),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_conn_open(i_conn_open), .i_conn_close(i_conn_close), .o_conn_accept(o_conn_accept),
    .i_req_valid(i_req_valid), .i_req_port(i_req_port), .i_req_unit(i_req_unit),
    .i_req_func(i_req_func), .o_req_ready(o_req_ready), .o_fwd_start(o_fwd_start),
    .o_fwd_unit(o_fwd_unit), .o_fwd_func(o_fwd_func), .o_local(o_local),
    .o_serial_busy(o_serial_busy), .i_rx_char(rx_char), .i_rx_done(rx_done),
    .o_rx_new_frame(o_rx_new_frame), .o_exc_valid(o_exc_valid), .o_exc_func(o_exc_func),
    .o_exc_code(o_exc_code));

  mgw_slave_model m (.i_clock(i_clock), .i_fwd_start(o_fwd_start), .i_fwd_unit(o_fwd_unit),
    .i_slow(slow), .o_rx_char(rx_char), .o_rx_done(rx_done));

  always #25 i_clock = ~i_clock;

  always @(posedge i_clock) begin
    cyc++;
    if (o_rx_new_frame === 1'b1) nf++;
    if (cyc == 40000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic t_regs();
    logic [15:0] d;
    rd(mgw_pkg::ADDR_TMO, d);
    `CHK("tmo", 16'h0009, d)
    rd(mgw_pkg::ADDR_UNIT, d);
    `CHK("unit", 16'h0001, d)
    rd(mgw_pkg::ADDR_MAXC, d);
    `CHK("maxc", 16'h0003, d)
    rd(mgw_pkg::ADDR_CHAR, d);
    `CHK("char", 16'h3A98, d)
    rd(4'h8, d);
    `CHK("unmapped", 16'h0000, d)
  endtask

  // Mode, protocol, port and unit id decide between forward and local handling.
  task automatic t_route();
    logic [7:0] ctl [9] = '{8'h00, 8'h09, 8'h01, 8'h01, 8'h05, 8'h01, 8'h01, 8'h01, 8'h03};
    logic [7:0] un [9] = '{8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'hFF, 8'h01, 8'h00, 8'h00};
    logic [1:0] ex [9] = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h3};
    int k;
    for (int i = 0; i < 9; i++) begin
      wr(mgw_pkg::ADDR_CTRL, {8'h00, ctl[i]});
      slow <= (i == 4);
      @(posedge i_clock);
      i_req_valid <= 1'b1;
      i_req_port <= (i == 2) ? 16'h01F7 : 16'h01F6;
      i_req_unit <= un[i];
      @(posedge i_clock);
      i_req_valid <= 1'b0;
      #1;
      `CHK("fwd_start", ex[i][1], o_fwd_start)
      `CHK("local", ex[i][0], o_local)
      if (ex[i][1]) begin
        `CHK("fwd_unit", un[i], o_fwd_unit)
        `CHK("fwd_func", 8'h03, o_fwd_func)
        `CHK("ready", 1'b0, o_req_ready)
      end
      k = 0;
      while (o_serial_busy !== 1'b0 && k < 3000) begin
        @(posedge i_clock);
        #1;
        k++;
      end
      `CHK("idle", 1'b0, o_serial_busy)
    end
  endtask

  // Two cycles a millisecond: timeout code 0 is 200 cycles, delay code 1 is 20.
  task automatic t_tmo();
    int k;
    wr(mgw_pkg::ADDR_CTRL, 16'h0001);
    wr(mgw_pkg::ADDR_TMO, 16'h0000);
    wr(mgw_pkg::ADDR_IFD, 16'h0001);
    slow <= 1'b1;
    @(posedge i_clock);
    i_req_valid <= 1'b1;
    i_req_port <= 16'h01F6;
    i_req_unit <= 8'h07;
    i_req_func <= 8'h04;
    @(posedge i_clock);
    i_req_valid <= 1'b0;
    k = 0;
    while (o_exc_valid !== 1'b1 && k < 400) begin
      @(posedge i_clock);
      #1;
      k++;
    end
    `CHK("tmo_cycles", 200, k)
    `CHK("exc_func", 8'h84, o_exc_func)
    `CHK("exc_code", 8'h0B, o_exc_code)
    repeat (19) @(posedge i_clock);
    #1 `CHK("hold_busy", 1'b1, o_serial_busy)
    repeat (6) @(posedge i_clock);
    #1 `CHK("hold_end", 1'b0, o_serial_busy)
    // The late reply of the slow slave must be over before the next scenario.
    repeat (250) @(posedge i_clock);
    slow <= 1'b0;
  endtask

  task automatic t_conn();
    logic [15:0] d;
    wr(mgw_pkg::ADDR_MAXC, 16'h0002);
    for (int i = 0; i < 3; i++) begin
      @(posedge i_clock) i_conn_open <= 1'b1;
      #1 `CHK("accept", (i < 2), o_conn_accept)
    end
    @(posedge i_clock);
    i_conn_open <= 1'b0;
    i_conn_close <= 1'b1;
    @(posedge i_clock);
    i_conn_close <= 1'b0;
    i_conn_open <= 1'b1;
    #1 `CHK("reaccept", 1'b1, o_conn_accept)
    @(posedge i_clock) i_conn_open <= 1'b0;
    rd(mgw_pkg::ADDR_STAT, d);
    `CHK("conn_count", 4'h2, d[7:4])
  endtask

  // Char time 10 cycles: silence is 35 cycles plus 10 per extension step.
  task automatic t_gap(input logic [7:0] ctl, input logic [3:0] ext, input int expn);
    wr(mgw_pkg::ADDR_CTRL, {8'h00, ctl});
    wr(mgw_pkg::ADDR_SIE, {12'h000, ext});
    wr(mgw_pkg::ADDR_CHAR, 16'h000A);
    repeat (100) @(posedge i_clock);
    m.chars(1);
    repeat (45) @(posedge i_clock);
    nf = 0;
    m.chars(1);
    repeat (10) @(posedge i_clock);
    `CHK("new_frame", expn, nf)
  endtask

  initial begin
    {i_clock, i_rst_n, i_wr, i_rd, i_conn_open, i_conn_close, i_req_valid, slow} = 8'h00;
    {i_addr, i_wdata, i_req_port, i_req_unit} = '0;
    i_req_func = 8'h03;
    {err_total, n_tests, cyc, nf} = '0;
    #1;
    `CHK("rst_ready", 1'b1, o_req_ready)
    `CHK("exc_code", 8'h0B, o_exc_code)
    `CHK("exc_func", 8'h80, o_exc_func)
    repeat (6) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_regs();
    t_route();
    t_tmo();
    t_conn();
    t_gap(8'h01, 4'h2, 0);
    t_gap(8'h00, 4'h2, 1);
    t_gap(8'h01, 4'h0, 1);
    finish_test();
  end
endmodule
`default_nettype wire

/* File: tb/mgw_slave_model.sv */
// Purpose: Downstream serial slave that answers forwarded requests.
// Assumes: Characters are rising edges on the receive pin, two cycles high.
// Notes:   Broadcasts get no answer, as on a real segment.
`timescale 1ns/100ps
`default_nettype none
module mgw_slave_model (
  input  wire logic       i_clock,
  input  wire logic       i_fwd_start,
  input  wire logic [7:0] i_fwd_unit,
  input  wire logic       i_slow,
  output logic            o_rx_char,
  output logic            o_rx_done
);
  initial begin
    o_rx_char = 1'b0;
    o_rx_done = 1'b0;
  end

  task automatic chars(input int n);
    repeat (n) begin
      @(posedge i_clock) o_rx_char <= 1'b1;
      repeat (2) @(posedge i_clock);
      o_rx_char <= 1'b0;
      repeat (2) @(posedge i_clock);
    end
  endtask

  // A unique unit id on a shared baud rate means exactly one slave answers.
  always @(posedge i_clock) begin
    if (i_fwd_start === 1'b1 && i_fwd_unit !== 8'h00) begin
      repeat (i_slow ? 400 : 20) @(posedge i_clock);
      chars(4);
      o_rx_done <= 1'b1;
      repeat (3) @(posedge i_clock);
      o_rx_done <= 1'b0;
    end
  end
endmodule
`default_nettype wire
